// *** common/adc_cfg_regs.vh ***
// Offsets, writable masks, field encodings and reset values of the converter configuration bank.
// Included by the register bank; holds definitions only.
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_W 9
`define ADDR_POWER_MODE_CONTROL 9'h010
`define ADDR_UNLOCK_KEY 9'h011
`define ADDR_WRITE_PROTOCOL_SELECT 9'h014
`define ADDR_READ_PROTOCOL_SELECT 9'h018
`define ADDR_OUTPUT_WORD_FORMAT 9'h01c
`define UNLOCK_KEY_VALUE 8'h69

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RESET_VALUE 8'h00
`define MASK_POWER_MODE_CONTROL 8'h03
`define MASK_WRITE_PROTOCOL_SELECT 8'h03
`define MASK_READ_PROTOCOL_SELECT 8'hdf
`define MASK_OUTPUT_WORD_FORMAT 8'h3f

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define READ_MODE_FOLLOW_INPUT 2'h0
`define READ_MODE_SOURCE_SYNC 2'h3
`define PATTERN_ZEROS 3'h4
`define PATTERN_ONES 3'h5
`define PATTERN_SINGLE_BITS 18'h15555
`define PATTERN_BIT_PAIRS 18'h03333
`define PATTERN_ONES_WORD 18'h3ffff

`endif

// *** verilog/adc_config_register_bank.v ***
// Configuration register bank of an 18-bit converter: three 8-bit registers,
// a keyed power register and the 20-bit output word formatter.
// Assumes writes and reads arrive as single-cycle strobes from the serial port decoder.
`timescale 1ns/1ps
`include "adc_cfg_regs.vh"

module adc_config_register_bank (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_wr_en,
	input wire [8:0] i_wr_addr,
	input wire [7:0] i_wr_data,
	input wire [8:0] i_rd_addr,
	output reg [7:0] o_rd_data,
	input wire [17:0] i_conv_result,
	output reg [19:0] o_data_word,
	output reg o_light_sleep_enable,
	output reg o_power_down_request,
	output reg o_input_cpol,
	output reg o_input_cpha,
	output reg o_output_cpol,
	output reg o_output_cpha,
	output reg o_source_sync,
	output reg [1:0] o_output_clock_source,
	output reg o_double_data_rate,
	output reg [3:0] o_lane_enable
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] power_mode_control_q;
	reg [7:0] power_mode_control_d;
	reg [7:0] write_protocol_select_q;
	reg [7:0] write_protocol_select_d;
	reg [7:0] read_protocol_select_q;
	reg [7:0] read_protocol_select_d;
	reg [7:0] output_word_format_q;
	reg [7:0] output_word_format_d;
	reg unlock_q;
	reg unlock_d;
	reg [7:0] rd_data_d;
	wire key_write;
	wire [3:0] wr_select;
	wire [3:0] rd_select;
	wire [1:0] read_mode;
	wire source_sync;
	wire [1:0] output_lane_count;
	wire [2:0] test_pattern_select;
	wire parity_enable;
	wire [1:0] parity_span_select;
	reg [17:0] payload;
	wire [3:0] nibble_parity;
	wire [3:0] span_parity;
	wire [3:0] lane_enable;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// One-hot register select: power, write protocol, read protocol, format
	function [3:0] reg_select;
		input [8:0] addr;
		begin
			case (addr)
				`ADDR_POWER_MODE_CONTROL: reg_select = 4'h1;
				`ADDR_WRITE_PROTOCOL_SELECT: reg_select = 4'h2;
				`ADDR_READ_PROTOCOL_SELECT: reg_select = 4'h4;
				`ADDR_OUTPUT_WORD_FORMAT: reg_select = 4'h8;
				default: reg_select = 4'h0;
			endcase
		end
	endfunction

	// Even parity of the bits under a mask
	function even_parity;
		input [17:0] bits;
		input [17:0] mask;
		begin
			even_parity = ^(bits & mask);
		end
	endfunction

	assign key_write = (i_wr_addr == `ADDR_UNLOCK_KEY) && (i_wr_data == `UNLOCK_KEY_VALUE);
	assign wr_select = reg_select(i_wr_addr);
	assign rd_select = reg_select(i_rd_addr);
	assign read_mode = read_protocol_select_q[1:0];
	assign source_sync = (read_mode == `READ_MODE_SOURCE_SYNC);
	assign output_lane_count = read_protocol_select_q[3:2];
	assign parity_span_select = output_word_format_q[5:4];
	assign parity_enable = output_word_format_q[3];
	assign test_pattern_select = output_word_format_q[2:0];

	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	always @* begin
		power_mode_control_d = power_mode_control_q;
		write_protocol_select_d = write_protocol_select_q;
		read_protocol_select_d = read_protocol_select_q;
		output_word_format_d = output_word_format_q;
		unlock_d = unlock_q;
		if (i_wr_en) begin
			unlock_d = key_write;
			if (wr_select[0] && unlock_q) begin
				power_mode_control_d = i_wr_data & `MASK_POWER_MODE_CONTROL;
			end
			if (wr_select[1]) begin
				write_protocol_select_d = i_wr_data & `MASK_WRITE_PROTOCOL_SELECT;
			end
			if (wr_select[2]) begin
				read_protocol_select_d = i_wr_data & `MASK_READ_PROTOCOL_SELECT;
			end
			if (wr_select[3]) begin
				output_word_format_d = i_wr_data & `MASK_OUTPUT_WORD_FORMAT;
			end
		end
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			power_mode_control_q <= `RESET_VALUE;
			write_protocol_select_q <= `RESET_VALUE;
			read_protocol_select_q <= `RESET_VALUE;
			output_word_format_q <= `RESET_VALUE;
			unlock_q <= 1'b0;
		end else begin
			power_mode_control_q <= power_mode_control_d;
			write_protocol_select_q <= write_protocol_select_d;
			read_protocol_select_q <= read_protocol_select_d;
			output_word_format_q <= output_word_format_d;
			unlock_q <= unlock_d;
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	always @* begin
		rd_data_d = 8'h00;
		if (rd_select[0]) begin
			rd_data_d = power_mode_control_q;
		end
		if (rd_select[1]) begin
			rd_data_d = write_protocol_select_q;
		end
		if (rd_select[2]) begin
			rd_data_d = read_protocol_select_q;
		end
		if (rd_select[3]) begin
			rd_data_d = output_word_format_q;
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= 8'h00;
		end else begin
			o_rd_data <= rd_data_d;
		end
	end

	// ----------------------------------------
	// Output word formatting
	// ----------------------------------------
	always @* begin
		if (!test_pattern_select[2]) begin
			payload = i_conv_result;
		end else begin
			case (test_pattern_select[1:0])
				2'h0: payload = 18'h00000;
				2'h1: payload = `PATTERN_ONES_WORD;
				2'h2: payload = `PATTERN_SINGLE_BITS;
				default: payload = `PATTERN_BIT_PAIRS;
			endcase
		end
	end

	// ----------------------------------------
	// Leading-span parity
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_nibble
			assign nibble_parity[g] = ^payload[17 - 4 * g -: 4];
		end
	endgenerate

	// Running parity over the first one to four nibbles
	assign span_parity[0] = nibble_parity[0];
	generate
		for (g = 1; g < 4; g = g + 1) begin : g_span
			assign span_parity[g] = span_parity[g - 1] ^ nibble_parity[g];
		end
	endgenerate

	// ----------------------------------------
	// Lane enables
	// ----------------------------------------
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_lane
			if (g == 0) begin : g_first
				assign lane_enable[g] = 1'b1;
			end else if (g == 1) begin : g_second
				assign lane_enable[g] = output_lane_count[1];
			end else begin : g_upper
				assign lane_enable[g] = &output_lane_count;
			end
		end
	endgenerate

	// ----------------------------------------
	// Registered control outputs
	// ----------------------------------------
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data_word <= 20'h00000;
			o_light_sleep_enable <= 1'b0;
			o_power_down_request <= 1'b0;
			o_input_cpol <= 1'b0;
			o_input_cpha <= 1'b0;
			o_output_cpol <= 1'b0;
			o_output_cpha <= 1'b0;
			o_source_sync <= 1'b0;
			o_output_clock_source <= 2'h0;
			o_double_data_rate <= 1'b0;
			o_lane_enable <= 4'h1;
		end else begin
			o_data_word[19:2] <= payload;
			o_data_word[1] <= parity_enable & even_parity(payload, 18'h3ffff);
			o_data_word[0] <= parity_enable & span_parity[parity_span_select];
			o_light_sleep_enable <= power_mode_control_q[1];
			o_power_down_request <= power_mode_control_q[0];
			o_input_cpol <= write_protocol_select_q[1];
			o_input_cpha <= write_protocol_select_q[0];
			o_output_cpol <= write_protocol_select_q[1];
			o_output_cpha <= write_protocol_select_q[0];
			o_source_sync <= source_sync;
			if (source_sync) begin
				o_output_clock_source <= read_protocol_select_q[7:6];
			end else begin
				o_output_clock_source <= 2'h0;
			end
			o_double_data_rate <= source_sync & read_protocol_select_q[4];
			o_lane_enable <= lane_enable;
		end
	end

endmodule // adc_config_register_bank

// *** testbench/adc_cfg_chk.sv ***
// Port assertions for the config bank.
// Assumes one clock, async active-low reset.
`timescale 1ns/1ps
module adc_cfg_chk (
	input wire i_clk, input wire i_rst_n, input wire i_wr_en,
	input wire [8:0] i_wr_addr, input wire [7:0] i_wr_data, input wire [8:0] i_rd_addr,
	input wire [7:0] o_rd_data, input wire o_light_sleep_enable, input wire o_power_down_request,
	input wire o_input_cpol, input wire o_input_cpha, input wire o_output_cpol,
	input wire o_output_cpha, input wire o_source_sync, input wire [1:0] o_output_clock_source,
	input wire o_double_data_rate
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
reg key_q;
always @(posedge i_clk or negedge i_rst_n)
	if (!i_rst_n) key_q <= 1'b0;
	else if (i_wr_en) key_q <= i_wr_addr == 9'h011 && i_wr_data == 8'h69;
chk_wp_rsvd: assert property (i_rd_addr == 9'h014 |=> o_rd_data[7:2] == 6'h0)
	else $error("rsvd bits");
chk_rp_bit5: assert property (i_rd_addr == 9'h018 |=> !o_rd_data[5])
	else $error("bit5 set");
chk_unmapped_zero: assert property (i_rd_addr == 9'h011 |=> o_rd_data == 8'h0)
	else $error("unmapped");
chk_power_read: assert property (i_rd_addr == 9'h010 |=>
	o_rd_data[1:0] == {o_light_sleep_enable, o_power_down_request}) else $error("pwr read");
chk_power_locked: assert property (i_wr_en && i_wr_addr == 9'h010 && !key_q |-> ##2
	$stable({o_light_sleep_enable, o_power_down_request})) else $error("locked");
chk_power_keyed: assert property (i_wr_en && i_wr_addr == 9'h010 && key_q |-> ##2
	{o_light_sleep_enable, o_power_down_request} == $past(i_wr_data[1:0], 2)) else $error("key");
chk_ssync_gate: assert property (!o_source_sync |->
	!o_double_data_rate && o_output_clock_source == 2'h0) else $error("ssync");
chk_out_follow: assert property ({o_output_cpol, o_output_cpha} ==
	{o_input_cpol, o_input_cpha}) else $error("follow");
endmodule // adc_cfg_chk
bind adc_config_register_bank adc_cfg_chk u_chk (.*);

// *** testbench/adc_cfg_host.sv ***
// Host model driving the write strobe bus.
// Assumes the bank takes a write on one rising edge.
`timescale 1ns/1ps
module adc_cfg_host (
	input wire i_clk,
	output reg o_wr_en,
	output reg [8:0] o_wr_addr,
	output reg [7:0] o_wr_data
);
initial {o_wr_en, o_wr_addr, o_wr_data} = 18'h0;
task wr(input [8:0] a, input [7:0] d);
	begin
		@(posedge i_clk) #1;
		{o_wr_en, o_wr_addr} = {1'b1, a};
		o_wr_data = a == 9'h018 ? {d[7:6], 1'b0, d[4:2], {2{d[1]}}} : d;
		@(posedge i_clk) #1;
		o_wr_en = 1'b0;
		o_wr_data = ~o_wr_data;
	end
endtask
task pwr(input [7:0] d);
	begin
		wr(9'h011, 8'h69);
		wr(9'h010, d);
	end
endtask
endmodule // adc_cfg_host

// *** testbench/tb.sv ***
// Self-checking bench for the config bank.
// Assumes the host model and bound checker.
`timescale 1ns/1ps
module tb;
reg clk = 0, rst_n = 0;
reg [8:0] rd_addr = 0;
reg [17:0] conv = 0;
wire wr_en, sl, pd, icp, ich, ocp, och, ss, ddr;
wire [8:0] wr_addr;
wire [7:0] wr_data, rd_data;
wire [19:0] word;
wire [1:0] cs;
wire [3:0] ln;
int fail_count = 0, samples_checked = 0, cyc = 0, m[4] = '{0, 0, 0, 0}, key = 0, i, j, a;
int ad[6] = '{'h10, 'h11, 'h14, 'h18, 'h1c, 'h12};
always #12.5 clk = ~clk;
adc_cfg_host u_host (.i_clk(clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
adc_config_register_bank u_adc_config_register_bank (.i_clk(clk), .i_rst_n(rst_n),
	.i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
	.o_rd_data(rd_data), .i_conv_result(conv), .o_data_word(word), .o_light_sleep_enable(sl),
	.o_power_down_request(pd), .o_input_cpol(icp), .o_input_cpha(ich), .o_output_cpol(ocp),
	.o_output_cpha(och), .o_source_sync(ss), .o_output_clock_source(cs),
	.o_double_data_rate(ddr), .o_lane_enable(ln));
always @(posedge clk) if (wr_en) begin
	if (wr_addr == 9'h010 && key) m[0] = wr_data & 3;
	if (wr_addr == 9'h014) m[1] = wr_data & 3;
	if (wr_addr == 9'h018) m[2] = wr_data & 'hdf;
	if (wr_addr == 9'h01c) m[3] = wr_data & 'h3f;
	key = wr_addr == 9'h011 && wr_data == 8'h69;
end
always @(posedge clk) if (++cyc == 20000) begin
	fail_count++;
	give_verdict;
end
task chk(input string n, input [19:0] e, input [19:0] g);
	begin
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	end
endtask
task rd(input [8:0] r, input [7:0] e);
	begin
		rd_addr = r;
		@(posedge clk) #1;
		chk("rd_data", e, rd_data);
	end
endtask
task ctl;
	begin
		chk("power", m[0], {sl, pd});
		chk("in_mode", m[1], {icp, ich});
		chk("out_mode", m[1], {ocp, och});
		chk("ssync", m[2][1:0] == 3 ? {m[2][7:6], m[2][4], 1'b1} : 0, {cs, ddr, ss});
		chk("lanes", m[2][3] ? (m[2][2] ? 15 : 3) : 1, ln);
	end
endtask
function [19:0] wexp(input [7:0] f, input [17:0] r);
	reg [17:0] p;
	begin
		p = !f[2] ? r : f[1] ? (f[0] ? 18'h03333 : 18'h15555) : {18{f[0]}};
		wexp = {p, f[3] & ^p, f[3] & ^(p >> (14 - 4 * f[5:4]))};
	end
endfunction
task give_verdict;
	begin
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end
endtask
initial begin
	void'($urandom(32'hb078));
	repeat (8) @(posedge clk);
	#1 rst_n = 1;
	for (i = 0; i < 6; i++) rd(ad[i], 0);
	ctl;
	$display("reset test done");
	for (i = 0; i < 4; i++) begin
		u_host.pwr(i | 'hfc);
		rd(9'h010, i);
		ctl;
	end
	$display("power test done");
	for (i = 0; i < 150; i++) begin
		a = ad[$urandom % 6];
		u_host.wr(a, $urandom % 2 ? 8'h69 : $urandom);
		for (j = 0; j < 4; j++) rd(9'h010 + 4 * j, m[j]);
		ctl;
	end
	$display("random test done");
	for (i = 0; i < 64; i++) begin
		u_host.wr(9'h01c, i);
		conv = $urandom;
		@(posedge clk) #1;
		chk("word", wexp(i, conv), word);
	end
	$display("format test done");
	give_verdict;
end
endmodule // tb
